// ===== design/swl_crc16.v
// Bitwise command CRC-16 accumulator, LSB first
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs.vh"

module swl_crc16 (
  // Clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_in,
  // Control
  input  wire        clear_in,
  input  wire        bit_valid_in,
  input  wire        bit_in,
  // Result
  output reg  [15:0] crc_out
);

  wire fb = crc_out[0] ^ bit_in;

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      crc_out <= `SWL_CRC_INIT;
    end else if (clear_in) begin
      crc_out <= `SWL_CRC_INIT;
    end else if (bit_valid_in) begin
      crc_out <= (crc_out >> 1) ^ (fb ? `SWL_CRC_POLY_REFL : 16'h0000);
    end
  end

endmodule // swl_crc16
`default_nettype wire

// ===== design/swl_link.v
// Single-wire sensor command link, device side
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs.vh"

module swl_link #(
  parameter [31:0] CONV_CYCLES  = `SWL_CONV_TIME_US * (`SWL_CLK_KHZ / 1000),
  parameter [31:0] RESET_CYCLES = `SWL_RESET_LOW_US * (`SWL_CLK_KHZ / 1000),
  parameter [31:0] OD_KEEP_CYCLES = `SWL_OD_KEEP_US * (`SWL_CLK_KHZ / 1000)
) (
  // Clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_in,
  // Open-drain data line
  input  wire        dq_in,
  output reg         dq_out,
  output reg         dq_oe_out,
  // Overdrive select from the ROM layer, pulse
  input  wire        od_set_in,
  // ROM layer has selected this device, function bytes follow
  input  wire        rom_sel_in,
  // Temperature sample from the converter
  input  wire [15:0] temp_sample_in,
  // Status
  output reg         converting_out,
  output reg         standby_out,
  output reg         overdrive_out,
  output reg         fifo_push_out,
  output reg  [15:0] fifo_data_out
);

  // Timing counts, least times rounded up to whole cycles
  localparam [31:0] STD_SAMPLE = (`SWL_STD_SAMPLE_NS * 1 + 4) / 5;
  localparam [31:0] OD_SAMPLE  = (`SWL_OD_SAMPLE_NS + 4) / 5;
  localparam [31:0] STD_RHOLD  = (`SWL_STD_READ_HOLD_NS + 4) / 5;
  localparam [31:0] OD_RHOLD   = (`SWL_OD_READ_HOLD_NS + 4) / 5;
  localparam [31:0] STD_PDH    = (`SWL_STD_PDH_NS + 4) / 5;
  localparam [31:0] OD_PDH     = (`SWL_OD_PDH_NS + 4) / 5;
  localparam [31:0] STD_PDL    = (`SWL_STD_PDL_NS + 4) / 5;
  localparam [31:0] OD_PDL     = (`SWL_OD_PDL_NS + 4) / 5;

  // Protocol states
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_PDH    = 4'h1;
  localparam [3:0] ST_PDL    = 4'h2;
  localparam [3:0] ST_ROM    = 4'h3;
  localparam [3:0] ST_CMD    = 4'h4;
  localparam [3:0] ST_ADDR   = 4'h5;
  localparam [3:0] ST_LEN    = 4'h6;
  localparam [3:0] ST_WDATA  = 4'h7;
  localparam [3:0] ST_RDATA  = 4'h8;
  localparam [3:0] ST_CRC    = 4'h9;
  localparam [3:0] ST_CONV   = 4'ha;
  localparam [3:0] ST_WAIT   = 4'hb;

  // Bit-slot phases
  localparam [1:0] SL_IDLE = 2'h0;
  localparam [1:0] SL_LOW  = 2'h1;
  localparam [1:0] SL_HIGH = 2'h2;

  reg  [7:0]  regs [0:`SWL_REG_DEPTH-1];
  reg         dq_meta;
  reg         dq_sync;
  reg         dq_prev;
  reg  [3:0]  state;
  reg  [1:0]  slot;
  reg  [31:0] low_cnt;
  reg  [31:0] tmr;
  reg  [2:0]  bit_idx;
  reg  [7:0]  shreg;
  reg  [7:0]  cmd;
  reg  [7:0]  addr;
  reg  [7:0]  len;
  reg  [15:0] crc_tx;
  reg         crc_bytes;
  reg         tx_bit;
  reg         pend_srst;
  reg         crc_clr;
  reg         crc_bv;
  reg         crc_bit;
  wire [15:0] crc_val;
  integer     i;

  wire fall     = dq_prev & ~dq_sync;
  wire rise     = ~dq_prev & dq_sync;
  wire tx_phase = (state == ST_RDATA) || (state == ST_CRC);

  function [31:0] pick;
    input        od;
    input [31:0] std_v;
    input [31:0] od_v;
    begin
      pick = od ? od_v : std_v;
    end
  endfunction

  swl_crc16 u_crc (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .clear_in     (crc_clr),
    .bit_valid_in (crc_bv),
    .bit_in       (crc_bit),
    .crc_out      (crc_val)
  );

  // Two-stage synchroniser for the bus pin
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dq_meta <= 1'b1;
      dq_sync <= 1'b1;
      dq_prev <= 1'b1;
    end else begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
      dq_prev <= dq_sync;
    end
  end

  // Register file; soft reset restores defaults (all zero)
  always @(posedge sys_clk_in) begin
    if (pend_srst && state == ST_WAIT) begin
      for (i = 0; i < `SWL_REG_DEPTH; i = i + 1)
        regs[i] <= 8'h00;
    end else if (state == ST_WDATA && slot == SL_LOW && tmr == pick(overdrive_out,
             STD_SAMPLE, OD_SAMPLE) && bit_idx == 3'h7) begin
      regs[addr] <= {dq_sync, shreg[7:1]};
    end
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state          <= ST_IDLE;
      slot           <= SL_IDLE;
      low_cnt        <= 32'h0;
      tmr            <= 32'h0;
      bit_idx        <= 3'h0;
      shreg          <= 8'h00;
      cmd            <= 8'h00;
      addr           <= 8'h00;
      len            <= 8'h00;
      crc_tx         <= 16'h0000;
      crc_bytes      <= 1'b0;
      tx_bit         <= 1'b1;
      pend_srst      <= 1'b0;
      crc_clr        <= 1'b1;
      crc_bv         <= 1'b0;
      crc_bit        <= 1'b0;
      dq_out         <= 1'b0;
      dq_oe_out      <= 1'b0;
      converting_out <= 1'b0;
      standby_out    <= 1'b1;
      overdrive_out  <= 1'b0;
      fifo_push_out  <= 1'b0;
      fifo_data_out  <= 16'h0000;
    end else begin
      crc_clr       <= 1'b0;
      crc_bv        <= 1'b0;
      fifo_push_out <= 1'b0;
      dq_out        <= 1'b0;
      if (od_set_in)
        overdrive_out <= 1'b1;
      // Bus low time for reset detection; our own presence and read-zero lows are not counted
      if (!dq_sync && !dq_oe_out)
        low_cnt <= low_cnt + 32'h1;
      else
        low_cnt <= 32'h0;
      if (state != ST_CONV && state != ST_PDH && state != ST_PDL && fall)
        standby_out <= 1'b0;

      if (rise && state != ST_CONV && low_cnt >= OD_KEEP_CYCLES &&
          (low_cnt >= RESET_CYCLES || !overdrive_out)) begin
        // Long low: bus reset, reply with presence
        if (low_cnt >= RESET_CYCLES)
          overdrive_out <= 1'b0;
        state     <= ST_PDH;
        tmr       <= 32'h0;
        slot      <= SL_IDLE;
        dq_oe_out <= 1'b0;
        pend_srst <= 1'b0;
      end else if (rise && state != ST_CONV && overdrive_out && low_cnt >= 32'h1 &&
                   low_cnt < OD_KEEP_CYCLES && low_cnt > pick(1'b1, STD_PDL, OD_PDL)) begin
        // Short reset in overdrive keeps the speed
        state     <= ST_PDH;
        tmr       <= 32'h0;
        slot      <= SL_IDLE;
        dq_oe_out <= 1'b0;
      end else begin
        case (state)
          ST_PDH: begin
            tmr <= tmr + 32'h1;
            if (tmr >= pick(overdrive_out, STD_PDH, OD_PDH)) begin
              tmr       <= 32'h0;
              dq_oe_out <= 1'b1; // Only falling edge the device makes
              state     <= ST_PDL;
            end
          end
          ST_PDL: begin
            tmr <= tmr + 32'h1;
            if (tmr >= pick(overdrive_out, STD_PDL, OD_PDL)) begin
              dq_oe_out <= 1'b0;
              state     <= ST_ROM;
              slot      <= SL_IDLE;
            end
          end
          ST_ROM: begin
            if (rom_sel_in) begin
              state   <= ST_CMD;
              bit_idx <= 3'h0;
              crc_clr <= 1'b1;
            end
          end
          ST_CONV: begin
            // Bus held high by strong pullup; no slots expected
            tmr <= tmr + 32'h1;
            if (tmr >= CONV_CYCLES) begin
              fifo_data_out  <= temp_sample_in;
              fifo_push_out  <= 1'b1;
              converting_out <= 1'b0;
              standby_out    <= 1'b1;
              state          <= ST_IDLE;
            end
          end
          ST_WAIT: begin
            // Both CRC bytes are out; act on the command now
            if (cmd == `SWL_CMD_CONVERT) begin
              state          <= ST_CONV;
              converting_out <= 1'b1;
              tmr            <= 32'h0;
            end else begin
              state       <= ST_IDLE;
              standby_out <= 1'b1;
            end
            pend_srst <= 1'b0;
          end
          ST_CMD, ST_ADDR, ST_LEN, ST_WDATA, ST_RDATA, ST_CRC: begin
            case (slot)
              SL_IDLE: begin
                if (fall) begin
                  slot <= SL_LOW; // Timer starts at master edge
                  tmr  <= 32'h0;
                  crc_bv  <= (state == ST_RDATA);
                  crc_bit <= tx_bit;
                  if (tx_phase && !tx_bit)
                    dq_oe_out <= 1'b1;
                end
              end
              SL_LOW: begin
                tmr <= tmr + 32'h1;
                if (tx_phase) begin
                  if (tmr >= pick(overdrive_out, STD_RHOLD, OD_RHOLD)) begin
                    dq_oe_out <= 1'b0;
                    slot      <= SL_HIGH;
                  end
                end else if (tmr == pick(overdrive_out, STD_SAMPLE, OD_SAMPLE)) begin
                  shreg   <= {dq_sync, shreg[7:1]};
                  crc_bv  <= 1'b1;
                  crc_bit <= dq_sync;
                  slot    <= SL_HIGH;
                end
              end
              SL_HIGH: begin
                // Wait for line high and the last CRC update before the next slot
                if (dq_sync && !crc_bv) begin
                  slot    <= SL_IDLE;
                  bit_idx <= bit_idx + 3'h1;
                  if (state == ST_RDATA) begin
                    tx_bit  <= shreg[1];
                    shreg   <= {1'b1, shreg[7:1]};
                  end else if (state == ST_CRC) begin
                    tx_bit <= crc_tx[1];
                    crc_tx <= {1'b1, crc_tx[15:1]};
                  end
                  if (bit_idx == 3'h7) begin
                    case (state)
                      ST_CMD: begin
                        cmd <= shreg;
                        if (shreg == `SWL_CMD_WRITE_REG || shreg == `SWL_CMD_READ_REG)
                          state <= ST_ADDR;
                        else if (shreg == `SWL_CMD_CONVERT ||
                                 shreg == `SWL_CMD_SOFT_RESET) begin
                          state     <= ST_CRC;
                          pend_srst <= (shreg == `SWL_CMD_SOFT_RESET);
                        end else
                          state <= ST_IDLE;
                      end
                      ST_ADDR: begin
                        addr  <= shreg;
                        state <= ST_LEN;
                      end
                      ST_LEN: begin
                        len <= shreg;
                        if (cmd == `SWL_CMD_WRITE_REG)
                          state <= ST_WDATA;
                        else begin
                          state  <= ST_RDATA;
                          shreg  <= regs[addr];
                          tx_bit <= regs[addr][0];
                        end
                      end
                      ST_WDATA, ST_RDATA: begin
                        addr <= addr + 8'h1;
                        len  <= len - 8'h1;
                        if (state == ST_RDATA) begin
                          shreg  <= regs[addr + 8'h1];
                          tx_bit <= regs[addr + 8'h1][0];
                        end
                        if (len == 8'h00)
                          state <= ST_CRC;
                      end
                      ST_CRC: begin
                        if (crc_bytes)
                          state <= ST_WAIT;
                        crc_bytes <= ~crc_bytes;
                      end
                      default: state <= ST_IDLE;
                    endcase
                  end
                end
              end
              default: slot <= SL_IDLE;
            endcase
            // Latch the inverted CRC on entry to the CRC phase
            if (state != ST_CRC && slot == SL_HIGH && dq_sync && !crc_bv && bit_idx == 3'h7 &&
                ((state == ST_CMD && (shreg == `SWL_CMD_CONVERT ||
                  shreg == `SWL_CMD_SOFT_RESET)) || (state != ST_CMD && state != ST_ADDR &&
                  state != ST_LEN && len == 8'h00))) begin
              crc_tx    <= ~crc_val;
              tx_bit    <= ~crc_val[0];
              crc_bytes <= 1'b0;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // swl_link
`default_nettype wire

// ===== design/swl_regs.vh
// Constants for the single-wire sensor command link
`ifndef SWL_REGS_VH
`define SWL_REGS_VH

// Function command codes
`define SWL_CMD_CONVERT      8'h44
`define SWL_CMD_WRITE_REG    8'hcc
`define SWL_CMD_READ_REG     8'h33
`define SWL_CMD_SOFT_RESET   8'h82

// Command CRC polynomial x^16+x^15+x^2+1, reflected for LSB-first feed
`define SWL_CRC_POLY_REFL    16'ha001
`define SWL_CRC_INIT         16'h0000

// Clock rate in kHz (200 MHz)
`define SWL_CLK_KHZ          200000

// Bus reset thresholds in microseconds
`define SWL_RESET_LOW_US     480
`define SWL_OD_KEEP_US       80

// Standard speed slot timing in nanoseconds
`define SWL_STD_SAMPLE_NS    30000
`define SWL_STD_READ_HOLD_NS 30000
`define SWL_STD_PDH_NS       30000
`define SWL_STD_PDL_NS       120000

// Overdrive slot timing in nanoseconds
`define SWL_OD_SAMPLE_NS     3000
`define SWL_OD_READ_HOLD_NS  3000
`define SWL_OD_PDH_NS        3000
`define SWL_OD_PDL_NS        12000

// Conversion time in microseconds
`define SWL_CONV_TIME_US     16000

// Register file size (byte addresses)
`define SWL_REG_DEPTH        256

`endif

// ===== dv/swl_link_assertions.sv
// Assertion checker for the single-wire link device
`timescale 1ns/1ps
`default_nettype none
module swl_link_chk #(
  parameter [31:0] CONV_CYCLES    = 100,
  parameter [31:0] RESET_CYCLES   = 200,
  parameter [31:0] OD_KEEP_CYCLES = 40
) (
  // Clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // Bus and control
  input wire logic        dq_in,
  input wire logic        dq_out,
  input wire logic        dq_oe_out,
  input wire logic        od_set_in,
  input wire logic        rom_sel_in,
  input wire logic [15:0] temp_sample_in,
  // Status
  input wire logic        converting_out,
  input wire logic        standby_out,
  input wire logic        overdrive_out,
  input wire logic        fifo_push_out,
  input wire logic [15:0] fifo_data_out
);
  localparam int RST  = RESET_CYCLES;
  localparam int CONV = CONV_CYCLES;
  // Run lengths; margins absorb the input synchroniser
  int   low_run;
  int   high_run;
  int   oe_run;
  int   conv_run;
  logic pres;
  logic long_seen;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_run <= 0;
      high_run <= 0;
      oe_run <= 0;
      conv_run <= 0;
      pres <= 1'b0;
      long_seen <= 1'b0;
    end else begin
      low_run <= dq_in ? 0 : low_run + 1;
      high_run <= dq_in ? high_run + 1 : 0;
      oe_run <= dq_oe_out ? oe_run + 1 : 0;
      conv_run <= converting_out ? conv_run + 1 : 0;
      pres <= (dq_oe_out && oe_run == 0) ? (high_run != 0) : pres;
      long_seen <= !od_set_in && (long_seen || low_run >= RST - 4);
    end
  end
  property p_od_enter; od_set_in |-> ##[1:3] overdrive_out; endproperty
  a_od_enter: assert property (p_od_enter) else $error("no od entry");
  property p_od_keep; $fell(overdrive_out) |-> long_seen; endproperty
  a_od_keep: assert property (p_od_keep) else $error("od lost");
  property p_od_clear; $rose(dq_in) && low_run >= RST + 4 |-> ##[0:8] !overdrive_out; endproperty
  a_od_clear: assert property (p_od_clear) else $error("od kept");
  property p_pres_dly; dq_oe_out && oe_run == 0 && high_run != 0 |-> high_run inside {[590:6010]}; endproperty
  a_pres_dly: assert property (p_pres_dly) else $error("bad presence delay");
  property p_rd_hold; !dq_oe_out && oe_run != 0 && !pres |-> oe_run >= 590; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("short read zero");
  property p_conv_len; $fell(converting_out) |-> conv_run inside {[CONV-2:CONV+2]}; endproperty
  a_conv_len: assert property (p_conv_len) else $error("bad conversion time");
  property p_push_data; fifo_push_out |-> fifo_data_out == temp_sample_in; endproperty
  a_push_data: assert property (p_push_data) else $error("bad sample");
  property p_wake; $fell(standby_out) |-> !$past(dq_in) || !$past(dq_in, 2) || !$past(dq_in, 3); endproperty
  a_wake: assert property (p_wake) else $error("woke without low");
  c_conv: cover property ($fell(converting_out));
  c_od_drop: cover property ($fell(overdrive_out));
  c_read0: cover property (dq_oe_out && !pres && oe_run == 8);
endmodule // swl_link_chk
bind swl_link swl_link_chk #(.CONV_CYCLES(CONV_CYCLES), .RESET_CYCLES(RESET_CYCLES),
  .OD_KEEP_CYCLES(OD_KEEP_CYCLES)) chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out), .od_set_in(od_set_in),
  .rom_sel_in(rom_sel_in), .temp_sample_in(temp_sample_in), .converting_out(converting_out),
  .standby_out(standby_out), .overdrive_out(overdrive_out), .fifo_push_out(fifo_push_out),
  .fifo_data_out(fifo_data_out));
`default_nettype wire

// ===== dv/swl_master_model.sv
// Bus master model for the open-drain line, overdrive slots
`timescale 1ns/1ps
`default_nettype none
module swl_master_model (
  input  wire logic sys_clk_in,
  input  wire logic dq_in,
  output var logic  pull_out,
  output var logic  spu_out
);
  event        got;
  logic [15:0] got_v;
  initial begin
    pull_out = 1'b0;
    spu_out = 1'b0;
  end
  // A one doubles as a read slot, sampled well inside the hold window
  task automatic slot(input logic b, output logic r);
    pull_out = 1'b1;
    repeat (b ? 10 : 650) @(negedge sys_clk_in);
    pull_out = 1'b0;
    repeat (b ? 190 : 1) @(negedge sys_clk_in);
    r = dq_in;
    repeat (b ? 460 : 9) @(negedge sys_clk_in);
  endtask
  task automatic send(input logic [7:0] v);
    logic r;
    for (int i = 0; i < 8; i++)
      slot(v[i], r);
  endtask
  task automatic recv();
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
      slot(1'b1, v[i]);
    got_v = {8'h00, v};
    -> got;
  endtask
  // Overdrive resets are short or full length, never in the undefined middle range
  task automatic bus_reset(input int low, input int msp, input int tail);
    pull_out = 1'b1;
    repeat (low) @(negedge sys_clk_in);
    pull_out = 1'b0;
    repeat (msp) @(negedge sys_clk_in);
    got_v = {15'h0000, dq_in};
    -> got;
    repeat (tail) @(negedge sys_clk_in);
  endtask
  task automatic hold_spu(input int n);
    spu_out = 1'b1;
    repeat (n) @(negedge sys_clk_in);
    spu_out = 1'b0;
  endtask
endmodule // swl_master_model
`default_nettype wire

// ===== dv/test_swl_link.sv
// Self-checking bench for the single-wire link device
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs.vh"
module test_swl_link;
  localparam int CONV = 2000;
  logic        sys_clk_in;
  logic        rst_in;
  logic        od_set_in;
  logic        rom_sel_in;
  logic [15:0] temp_sample_in;
  wire         dq_oe_out;
  wire         dq_out;
  wire         converting_out;
  wire         standby_out;
  wire         overdrive_out;
  wire         fifo_push_out;
  wire  [15:0] fifo_data_out;
  wire         pull;
  wire         dq_line;
  int          seed;
  int          n_mismatch;
  int          samples_checked;
  logic [15:0] expq[$];
  // Pull-up unless a party pulls; the strong pullup only adds current
  assign dq_line = !(pull || dq_oe_out);
  // Reset thresholds sit above every overdrive slot low and the overdrive presence low
  swl_link #(.CONV_CYCLES(CONV), .RESET_CYCLES(4000), .OD_KEEP_CYCLES(3000)) dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .dq_in(dq_line), .dq_out(dq_out),
    .dq_oe_out(dq_oe_out), .od_set_in(od_set_in), .rom_sel_in(rom_sel_in),
    .temp_sample_in(temp_sample_in), .converting_out(converting_out),
    .standby_out(standby_out), .overdrive_out(overdrive_out),
    .fifo_push_out(fifo_push_out), .fifo_data_out(fifo_data_out));
  swl_master_model m (.sys_clk_in(sys_clk_in), .dq_in(dq_line), .pull_out(pull), .spu_out());
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [15:0] crc_inv(input logic [7:0] b);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return ~c;
  endfunction
  // Short overdrive reset, selection, one command byte, both CRC bytes
  task automatic cmd(input logic [7:0] c);
    logic [15:0] e;
    e = crc_inv(c);
    expq.push_back(16'h0000);
    m.bus_reset(2700, 1800, 1400);
    check(overdrive_out, 1'b1);
    check(dq_out, 1'b0);
    rom_sel_in = 1'b1;
    @(negedge sys_clk_in) rom_sel_in = 1'b0;
    m.send(c);
    expq.push_back({8'h00, e[7:0]});
    m.recv();
    check(converting_out, 1'b0);
    expq.push_back({8'h00, e[15:8]});
    m.recv();
  endtask
  always @(m.got) check(m.got_v, expq.pop_front());
  always @(posedge sys_clk_in)
    if (fifo_push_out === 1'b1)
      check(fifo_data_out, expq.pop_front());
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #460000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    seed = 95946;
    n_mismatch = 0;
    samples_checked = 0;
    rst_in = 1'b1;
    od_set_in = 1'b0;
    rom_sel_in = 1'b0;
    temp_sample_in = 16'($random(seed));
    repeat (3) @(negedge sys_clk_in);
    rst_in = 1'b0;
    check(overdrive_out, 1'b0);
    check(standby_out, 1'b1);
    expq.push_back(16'h0000);
    m.bus_reset(4200, 18000, 13000);
    od_set_in = 1'b1;
    @(negedge sys_clk_in) od_set_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    check(overdrive_out, 1'b1);
    cmd(`SWL_CMD_CONVERT);
    expq.push_back(temp_sample_in);
    check(converting_out, 1'b1);
    m.hold_spu(CONV + 200);
    check(standby_out, 1'b1);
    cmd(`SWL_CMD_SOFT_RESET);
    repeat (20) @(negedge sys_clk_in);
    check(standby_out, 1'b1);
    expq.push_back(16'h0001);
    m.bus_reset(4200, 10, 0);
    check(overdrive_out, 1'b0);
    // Let the last presence sample reach its compare before closing
    @(negedge sys_clk_in);
    check(16'(expq.size()), 16'h0000);
    print_verdict();
  end
endmodule // test_swl_link
`default_nettype wire
